// ---- logic/flash_host.sv ----
`timescale 1ns/1ns
// Operation
// (R1) array is 524288 bytes, 19-bit byte address, 8-bit data.
// (R2) eight 64K sectors chosen by the top three address bits.
// (R3) read: chip select and output gate low, write strobe high.
// (R4) device floats data unless chip select and output gate both low.
// (R5) chip select high puts the device in standby.
// (R6) deselecting does not stop a running program or erase.
// (R7) high-voltage id level on bit 9 with bits 1 and 6 low gives id.
// (R8) id readout: bit 0 low maker code, bit 0 high device code.
// (R9) id codes also readable after command entry sequence.
// (R10) write: chip select low, gate high, pulse strobe low.
// (R11) device also accepts strobe held low with chip select pulsed.
// (R12) wrong or out-of-order write returns interpreter to read mode.
// (R13) command writes never touch array contents directly.
// (R14) interpreter starts program, erase, suspend and resume.
// (R15) device returns to read mode after program or erase.
// (R16) supply lockout aborts operation and returns to read mode.
// (R17) program and erase commands ignored while one runs.
// (R18) device powers up in read mode.
// (R19) sector erase supports suspend and resume.
// (R20) protected sectors reject program and erase.
// (R21) byte program: two unlocks, program command, address and data.
// (R22) chip erase: two unlocks, setup, two unlocks, erase command.
// (R23) programming a 1 over a 0 raises the timeout status bit.
// (R24) reset command sequence returns to read mode.
// (R25) device synchronises its pins and flags id level separately.
// (R26) next write after a sequence starts a new sequence.
module flash_host #(
	parameter int ADDR_W = flash_host_pkg::ADDR_W,
	parameter int DATA_W = flash_host_pkg::DATA_W
) (
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic                       req_valid,
	output logic                            req_ready,
	input  wire flash_host_pkg::op_type     req_op,
	input  wire logic [ADDR_W-1:0]          req_addr,
	input  wire logic [DATA_W-1:0]          req_data,
	input  wire logic                       req_use_id_level,
	input  wire logic                       req_cs_strobe,
	output logic                            rsp_valid,
	output logic [DATA_W-1:0]               rsp_data,
	output logic                            rsp_timeout,
	output flash_host_pkg::flash_pins_type  pins,
	input  wire logic [DATA_W-1:0]          dq_in
);
	typedef enum {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_DONE
	} state_type;

	// look up bus cycle idx of an operation's sequence
	function automatic flash_host_pkg::bus_cycle_type seq_cycle(
		input flash_host_pkg::op_type op,
		input logic [2:0]             idx,
		input logic [18:0]            addr,
		input logic [7:0]             data
	);
		flash_host_pkg::bus_cycle_type c;
		c = '{addr: flash_host_pkg::UNLOCK_ADDR1, data: flash_host_pkg::UNLOCK_DATA1};
		unique case (idx)
			3'h0: begin
				if (op == flash_host_pkg::OP_SUSPEND) begin
					c.data = flash_host_pkg::CMD_SUSPEND; // [R19]
				end else if (op == flash_host_pkg::OP_RESUME) begin
					c.data = flash_host_pkg::CMD_RESUME; // [R19]
				end
			end
			3'h1, 3'h4: begin
				c = '{addr: flash_host_pkg::UNLOCK_ADDR2, data: flash_host_pkg::UNLOCK_DATA2};
			end
			3'h2: begin
				unique case (op)
					flash_host_pkg::OP_RESET:   c.data = flash_host_pkg::CMD_RESET; // [R24]
					flash_host_pkg::OP_IDENT:   c.data = flash_host_pkg::CMD_IDENT; // [R9]
					flash_host_pkg::OP_PROGRAM: c.data = flash_host_pkg::CMD_PROGRAM; // [R21]
					default:                    c.data = flash_host_pkg::CMD_ERASE; // [R22]
				endcase
			end
			3'h3: begin
				if (op == flash_host_pkg::OP_PROGRAM) begin
					c = '{addr: addr, data: data}; // [R21]
				end
			end
			default: begin
				if (op == flash_host_pkg::OP_SECTOR_ERASE) begin
					c = '{addr: addr, data: flash_host_pkg::CMD_SECTOR};
				end else begin
					c.data = flash_host_pkg::CMD_CHIP; // [R22]
				end
			end
		endcase
		return c;
	endfunction : seq_cycle

	// number of write cycles an operation takes
	function automatic logic [2:0] seq_len(input flash_host_pkg::op_type op);
		unique case (op)
			flash_host_pkg::OP_READ:    return 3'h0;
			flash_host_pkg::OP_SUSPEND,
			flash_host_pkg::OP_RESUME:  return flash_host_pkg::SEQ_LEN_ONE;
			flash_host_pkg::OP_RESET,
			flash_host_pkg::OP_IDENT:   return 3'h3;
			flash_host_pkg::OP_PROGRAM: return 3'h4;
			default:                    return 3'h6;
		endcase
	endfunction : seq_len

	state_type                      state_r, state_nxt;
	flash_host_pkg::op_type         op_r, op_nxt;
	logic [2:0]                     idx_r, idx_nxt;
	logic [3:0]                     cnt_r, cnt_nxt;
	logic [ADDR_W-1:0]              addr_r, addr_nxt;
	logic [DATA_W-1:0]              data_r, data_nxt;
	logic                           idl_r, idl_nxt;
	logic                           csw_r, csw_nxt;
	logic [DATA_W-1:0]              rdata_r, rdata_nxt;
	logic                           rvalid_r, rvalid_nxt;
	flash_host_pkg::flash_pins_type pins_r, pins_nxt;
	flash_host_pkg::bus_cycle_type  cyc;

	assign req_ready   = (state_r == ST_IDLE);
	assign rsp_valid   = rvalid_r;
	assign rsp_data    = rdata_r;
	assign rsp_timeout = rdata_r[flash_host_pkg::TIMEOUT_BIT]; // [R23]
	assign pins        = pins_r;
	assign cyc         = seq_cycle(op_r, idx_r, addr_r, data_r);

	// sequencer: one bus cycle at a time, idle pins park in standby
	always_comb begin
		state_nxt  = state_r;
		op_nxt     = op_r;
		idx_nxt    = idx_r;
		cnt_nxt    = cnt_r;
		addr_nxt   = addr_r;
		data_nxt   = data_r;
		idl_nxt    = idl_r;
		csw_nxt    = csw_r;
		rdata_nxt  = rdata_r;
		rvalid_nxt = 1'b0;
		pins_nxt   = pins_r;
		unique case (state_r)
			ST_IDLE: begin
				pins_nxt.chip_sel_n = 1'b1; // [R5]
				pins_nxt.out_gate_n = 1'b1;
				pins_nxt.write_n    = 1'b1;
				pins_nxt.dq_oe_n    = 1'b1;
				pins_nxt.id_level   = 1'b0;
				if (req_valid) begin
					op_nxt   = req_op;
					addr_nxt = req_addr; // [R1] [R2]
					data_nxt = req_data;
					idl_nxt  = req_use_id_level;
					csw_nxt  = req_cs_strobe;
					idx_nxt  = 3'h0; // [R26]
					cnt_nxt  = flash_host_pkg::ACCESS_CNT;
					state_nxt = (seq_len(req_op) == 3'h0) ? ST_READ : ST_SETUP;
				end
			end
			ST_SETUP: begin
				// address and data out, gate high; strobe edge comes next [R13]
				pins_nxt.addr       = cyc.addr;
				pins_nxt.dq_out     = cyc.data;
				pins_nxt.dq_oe_n    = 1'b0;
				pins_nxt.out_gate_n = 1'b1;
				pins_nxt.chip_sel_n = csw_r; // [R11]
				pins_nxt.write_n    = ~csw_r;
				cnt_nxt   = flash_host_pkg::STROBE_CNT;
				state_nxt = ST_STROBE;
			end
			ST_STROBE: begin
				pins_nxt.chip_sel_n = 1'b0; // [R10] [R11]
				pins_nxt.write_n    = 1'b0;
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// rising edge latches data; only the strobing pin rises between cycles, so standby only in select strobe mode
				if (csw_r) begin
					pins_nxt.chip_sel_n = 1'b1;
				end else begin
					pins_nxt.write_n = 1'b1;
				end
				idx_nxt = idx_r + 3'h1;
				if (idx_r + 3'h1 == seq_len(op_r)) begin
					state_nxt = ST_DONE; // [R12] [R17]
				end else begin
					state_nxt = ST_SETUP;
				end
			end
			ST_READ: begin
				// read or id readout with strobe high [R3] [R4]
				pins_nxt.addr       = addr_r;
				pins_nxt.dq_oe_n    = 1'b1;
				pins_nxt.write_n    = 1'b1;
				pins_nxt.chip_sel_n = 1'b0;
				pins_nxt.out_gate_n = 1'b0;
				pins_nxt.id_level   = idl_r; // [R7] [R8] [R25]
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					rdata_nxt  = dq_in;
					rvalid_nxt = 1'b1;
					state_nxt  = ST_DONE;
				end
			end
			default: begin
				// done: back to standby, ready for a new request [R6] [R15]
				pins_nxt.chip_sel_n = 1'b1;
				pins_nxt.out_gate_n = 1'b1;
				pins_nxt.write_n    = 1'b1;
				pins_nxt.dq_oe_n    = 1'b1;
				pins_nxt.id_level   = 1'b0;
				if (op_r != flash_host_pkg::OP_READ) begin
					rvalid_nxt = 1'b1;
					rdata_nxt  = '0;
				end
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// registers; pins park in standby from reset [R16] [R18]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r  <= ST_IDLE;
			op_r     <= flash_host_pkg::OP_READ;
			idx_r    <= 3'h0;
			cnt_r    <= 4'h0;
			addr_r   <= '0;
			data_r   <= '0;
			idl_r    <= 1'b0;
			csw_r    <= 1'b0;
			rdata_r  <= '0;
			rvalid_r <= 1'b0;
			pins_r   <= '{addr: 19'h00000, dq_out: 8'h00, dq_oe_n: 1'b1, chip_sel_n: 1'b1,
			              out_gate_n: 1'b1, write_n: 1'b1, id_level: 1'b0};
		end else begin
			state_r  <= state_nxt;
			op_r     <= op_nxt;
			idx_r    <= idx_nxt;
			cnt_r    <= cnt_nxt;
			addr_r   <= addr_nxt;
			data_r   <= data_nxt;
			idl_r    <= idl_nxt;
			csw_r    <= csw_nxt;
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			pins_r   <= pins_nxt;
		end
	end
endmodule : flash_host

// ---- logic/flash_host_pkg.sv ----
package flash_host_pkg;
	// bus widths and array geometry
	localparam int ADDR_W       = 19;
	localparam int DATA_W       = 8;
	localparam int SECTOR_BITS  = 3;
	localparam int ARRAY_BYTES  = 524288;
	// command sequence addresses and data
	localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
	localparam logic [18:0] UNLOCK_ADDR2 = 19'h02AAA;
	localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0]  CMD_RESET    = 8'hF0;
	localparam logic [7:0]  CMD_IDENT    = 8'h90;
	localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
	localparam logic [7:0]  CMD_ERASE    = 8'h80;
	localparam logic [7:0]  CMD_CHIP     = 8'h10;
	localparam logic [7:0]  CMD_SECTOR   = 8'h30;
	localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
	localparam logic [7:0]  CMD_RESUME   = 8'h30;
	// identification readout address bits
	localparam logic [18:0] ID_MAKER_ADDR  = 19'h00000;
	localparam logic [18:0] ID_DEVICE_ADDR = 19'h00001;
	localparam logic [18:0] ID_PROT_ADDR   = 19'h00002;
	localparam int          TIMEOUT_BIT    = 5;
	// bus phase timing, 100 ns clock
	localparam int CLK_NS      = 100;
	localparam int ACCESS_NS   = 200;
	localparam int STROBE_NS   = 100;
	localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
	localparam logic [2:0] SEQ_LEN_ONE = 3'h1;

	// host operation codes
	typedef enum logic [2:0] {
		OP_READ, OP_RESET, OP_IDENT, OP_PROGRAM, OP_CHIP_ERASE,
		OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME
	} op_type;

	// one bus cycle of a sequence
	typedef struct packed {
		logic [18:0] addr;
		logic [7:0]  data;
	} bus_cycle_type;

	// pins toward the flash
	typedef struct packed {
		logic [18:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe_n;
		logic        chip_sel_n;
		logic        out_gate_n;
		logic        write_n;
		logic        id_level;
	} flash_pins_type;
endpackage : flash_host_pkg

// ---- test/flash_host_properties.sv ----
`timescale 1ns/1ns
module flash_host_checker (
	input wire logic                           clk,
	input wire logic                           reset_n,
	input wire logic                           req_valid,
	input wire logic                           req_ready,
	input wire flash_host_pkg::op_type         req_op,
	input wire logic                           rsp_valid,
	input wire logic [7:0]                     rsp_data,
	input wire logic                           rsp_timeout,
	input wire flash_host_pkg::flash_pins_type pins
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// a request is taken on an edge with valid and ready
	wire logic take = req_valid && req_ready;

	a_read_no_write: assert property (!pins.out_gate_n |-> pins.write_n)
		else $error("gate low while strobe low");
	a_write_gate_up: assert property (!pins.write_n && !pins.chip_sel_n |-> pins.out_gate_n)
		else $error("write with gate low");
	a_no_contention: assert property (!pins.dq_oe_n |-> pins.out_gate_n)
		else $error("host drives data during read");
	a_id_bits_low: assert property (pins.id_level |-> !pins.addr[1] && !pins.addr[6])
		else $error("id level with bit 1 or 6 high");
	a_read_latency: assert property (take && req_op == flash_host_pkg::OP_READ
		|-> ##1 !rsp_valid[*2] ##1 rsp_valid)
		else $error("read answer not three cycles after take");
	a_program_len: assert property (take && req_op == flash_host_pkg::OP_PROGRAM
		|-> ##14 rsp_valid)
		else $error("program not four bus cycles");
	a_erase_len: assert property (take && req_op == flash_host_pkg::OP_CHIP_ERASE
		|-> ##20 rsp_valid)
		else $error("chip erase not six bus cycles");
	a_strobe_pulse: assert property ($fell(pins.write_n) && !pins.chip_sel_n
		|=> $rose(pins.write_n))
		else $error("write strobe not one cycle");
	a_select_pulse: assert property ($fell(pins.chip_sel_n) && !pins.write_n
		|=> $rose(pins.chip_sel_n))
		else $error("select strobe not one cycle");
	a_timeout_bit: assert property (rsp_valid |-> rsp_timeout == rsp_data[5])
		else $error("timeout flag differs from bit 5");
	// main scenarios reached
	cover property (take && req_op == flash_host_pkg::OP_IDENT);
	cover property (rsp_valid && rsp_timeout);
	cover property ($fell(pins.chip_sel_n) && !pins.write_n);
	cover property (take && req_op == flash_host_pkg::OP_SUSPEND);
endmodule : flash_host_checker
bind flash_host flash_host_checker chk_u (.clk, .reset_n, .req_valid, .req_ready, .req_op,
	.rsp_valid, .rsp_data, .rsp_timeout, .pins);

// ---- test/flash_device_model.sv ----
`timescale 1ns/1ns
module flash_device_model #(
	parameter logic [7:0] MAKER_CODE  = 8'h3C, // arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'hC3, // arbitrary value
	parameter int         BUSY_NS     = 3000,
	parameter int         ERASE_NS    = 20000,
	parameter logic [7:0] PROT_MASK   = 8'h40 // sector 6 read-only
) (
	input  wire logic                           clk,
	input  wire flash_host_pkg::flash_pins_type pins,
	output logic [7:0]                          dq
);
	logic [7:0]  mem [logic [18:0]];
	logic [2:0]  step    = 3'h0;
	logic        id_mode = 1'b0;
	logic        busy    = 1'b0;
	logic        tflag   = 1'b0;
	logic        sect    = 1'b0;
	logic        susp    = 1'b0;
	logic        lockout = 1'b0;
	logic [7:0]  last    = 8'h00;
	logic [7:0]  rd;
	logic [7:0]  d;
	logic [7:0]  o;
	logic [18:0] a;
	wire logic   act   = !pins.chip_sel_n && !pins.write_n;
	wire logic   drive = !pins.chip_sel_n && !pins.out_gate_n && pins.write_n;
	wire logic   id_on = id_mode || (pins.id_level && !pins.addr[1] && !pins.addr[6]);
	// read path: id codes, status while busy and not suspended or failed, else array byte
	always @* begin
		rd = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
		if ((busy && !susp) || tflag)
			rd = {2'b00, tflag, 5'h00};
		if (id_on)
			rd = pins.addr[0] ? DEVICE_CODE : MAKER_CODE;
	end
	// released bus shows the inverse of the last byte
	assign dq = drive ? rd : ~last;
	always @(posedge clk) if (drive) last <= rd;
	// embedded operation runs on regardless of select, then back to read
	always @(posedge busy) begin
		#(sect ? ERASE_NS : BUSY_NS);
		busy = 1'b0;
		sect = 1'b0;
		susp = 1'b0;
	end
	// supply lockout drops any sequence, id mode or running operation back to read
	always @(posedge lockout) begin
		step    = 3'h0;
		id_mode = 1'b0;
		busy    = 1'b0;
	end
	// command steps advance as each strobe ends
	always @(negedge act) begin
		a = pins.addr;
		d = pins.dq_out;
		if (busy && sect && !$isunknown(pins)) begin
			if (d == 8'hB0) susp = 1'b1;
			if (d == 8'h30) susp = 1'b0;
		end else if (!busy && !$isunknown(pins)) begin
			case (step)
			3'h0, 3'h4: step = (a[14:0] == 15'h5555 && d == 8'hAA) ? step + 3'h1 : 3'h0;
			3'h1, 3'h5: step = (a[14:0] == 15'h2AAA && d == 8'h55) ? step + 3'h1 : 3'h0;
			3'h2: begin
				id_mode = (d == 8'h90);
				tflag = 1'b0;
				step = (d == 8'hA0) ? 3'h3 : (d == 8'h80) ? 3'h4 : 3'h0;
			end
			3'h3: begin
				o = mem.exists(a) ? mem[a] : 8'hFF;
				tflag = |(d & ~o);
				if (!PROT_MASK[a[18:16]]) mem[a] = o & d;
				busy = 1'b1;
				step = 3'h0;
			end
			default: begin
				// erase whole chip or one sector, protected sectors kept
				if (d == 8'h10 || d == 8'h30)
					foreach (mem[k])
						if ((d == 8'h10 || k[18:16] == a[18:16]) && !PROT_MASK[k[18:16]])
							mem[k] = 8'hFF;
				sect = (d == 8'h30);
				busy = (d == 8'h10 || d == 8'h30);
				step = 3'h0;
			end
			endcase
		end
	end
endmodule : flash_device_model

// ---- test/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	logic                           clk              = 1'b0;
	logic                           reset_n          = 1'b0;
	logic                           req_valid        = 1'b0;
	logic                           req_ready;
	flash_host_pkg::op_type         req_op           = flash_host_pkg::OP_READ;
	logic [18:0]                    req_addr         = 19'h00000;
	logic [7:0]                     req_data         = 8'h00;
	logic                           req_use_id_level = 1'b0;
	logic                           req_cs_strobe    = 1'b0;
	logic                           rsp_valid;
	logic [7:0]                     rsp_data;
	logic                           rsp_timeout;
	flash_host_pkg::flash_pins_type pins;
	logic [7:0]                     dq_in;
	int                             fails            = 0;
	int                             num_checks       = 0;
	always #50 clk = ~clk;
	flash_host dut_u (.clk, .reset_n, .req_valid, .req_ready, .req_op, .req_addr, .req_data,
		.req_use_id_level, .req_cs_strobe, .rsp_valid, .rsp_data, .rsp_timeout, .pins, .dq_in);
	flash_device_model dev_u (.clk, .pins, .dq(dq_in));
	task automatic end_sim;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// bounded wait for a flag seen high at an edge
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		@(posedge clk);
		while (s !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > 40) begin
				fails++;
				end_sim();
			end
		end
	endtask : wait_hi
	// one request; md is id level then select strobe
	task automatic run(input flash_host_pkg::op_type op, input logic [18:0] a, input logic [7:0] d,
		input logic [1:0] md, output logic [7:0] q);
		req_op           <= op;
		req_addr         <= a;
		req_data         <= d;
		req_use_id_level <= md[1];
		req_cs_strobe    <= md[0];
		req_valid        <= 1'b1;
		wait_hi(req_ready);
		req_valid <= 1'b0;
		wait_hi(rsp_valid);
		q = rsp_data;
		if (op != flash_host_pkg::OP_READ)
			repeat (40) @(posedge clk);
	endtask : run
	task automatic t_program;
		logic [7:0] q;
		run(flash_host_pkg::OP_READ, 19'h12345, 8'h00, 2'b00, q);
		check(q, 8'hFF);
		run(flash_host_pkg::OP_PROGRAM, 19'h00000, 8'h5A, 2'b00, q);
		run(flash_host_pkg::OP_PROGRAM, 19'h7FFFF, 8'hA5, 2'b01, q);
		run(flash_host_pkg::OP_READ, 19'h00000, 8'h00, 2'b00, q);
		check(q, 8'h5A);
		run(flash_host_pkg::OP_READ, 19'h7FFFF, 8'h00, 2'b00, q);
		check(q, 8'hA5);
		run(flash_host_pkg::OP_PROGRAM, 19'h60000, 8'h00, 2'b00, q);
		run(flash_host_pkg::OP_READ, 19'h60000, 8'h00, 2'b00, q);
		check(q, 8'hFF);
	endtask : t_program
	task automatic t_fail_bit;
		logic [7:0] q;
		run(flash_host_pkg::OP_PROGRAM, 19'h00000, 8'hFF, 2'b00, q);
		run(flash_host_pkg::OP_READ, 19'h00000, 8'h00, 2'b00, q);
		check({7'h00, rsp_timeout}, 8'h01);
		run(flash_host_pkg::OP_RESET, 19'h00000, 8'h00, 2'b00, q);
		run(flash_host_pkg::OP_READ, 19'h00000, 8'h00, 2'b00, q);
		check(q, 8'h5A);
	endtask : t_fail_bit
	task automatic t_ident;
		logic [7:0] q;
		run(flash_host_pkg::OP_READ, 19'h00000, 8'h00, 2'b10, q);
		check(q, dev_u.MAKER_CODE);
		run(flash_host_pkg::OP_READ, 19'h00001, 8'h00, 2'b10, q);
		check(q, dev_u.DEVICE_CODE);
		run(flash_host_pkg::OP_IDENT, 19'h00000, 8'h00, 2'b00, q);
		run(flash_host_pkg::OP_READ, 19'h00001, 8'h00, 2'b00, q);
		check(q, dev_u.DEVICE_CODE);
		run(flash_host_pkg::OP_RESET, 19'h00000, 8'h00, 2'b00, q);
		run(flash_host_pkg::OP_READ, 19'h00001, 8'h00, 2'b00, q);
		check(q, 8'hFF);
		run(flash_host_pkg::OP_IDENT, 19'h00000, 8'h00, 2'b00, q);
		dev_u.lockout <= 1'b1;
		@(posedge clk);
		dev_u.lockout <= 1'b0;
		run(flash_host_pkg::OP_READ, 19'h00001, 8'h00, 2'b00, q);
		check(q, 8'hFF);
	endtask : t_ident
	task automatic t_erase;
		logic [7:0] q;
		run(flash_host_pkg::OP_SECTOR_ERASE, 19'h70000, 8'h00, 2'b00, q);
		run(flash_host_pkg::OP_SUSPEND, 19'h00000, 8'h00, 2'b00, q);
		check(q, 8'h00);
		run(flash_host_pkg::OP_READ, 19'h00000, 8'h00, 2'b00, q);
		check(q, 8'h5A);
		run(flash_host_pkg::OP_RESUME, 19'h00000, 8'h00, 2'b00, q);
		repeat (100) @(posedge clk);
		run(flash_host_pkg::OP_READ, 19'h7FFFF, 8'h00, 2'b00, q);
		check(q, 8'hFF);
		run(flash_host_pkg::OP_READ, 19'h00000, 8'h00, 2'b00, q);
		check(q, 8'h5A);
		run(flash_host_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00, 2'b00, q);
		run(flash_host_pkg::OP_READ, 19'h00000, 8'h00, 2'b00, q);
		check(q, 8'hFF);
	endtask : t_erase
	// reset, then the scenarios in turn
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_program();
		t_fail_bit();
		t_ident();
		t_erase();
		end_sim();
	end
endmodule : testbench
